// >>> rtl/bds_bkpt_cmp.sv
`timescale 1ns/10ps
// ============================================================
// breakpoint comparator
module bds_bkpt_cmp #(
  parameter int AW = 16
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          enable,
  input  wire logic          force_sel,
  input  wire logic [AW-1:0] match_addr,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic          cpu_addr_valid,
  output logic               force_hit,
  output logic               tag_hit
);
  logic hit;
  logic force_hit_d;
  logic tag_hit_d;

  always_comb begin
    hit         = enable && cpu_addr_valid && (cpu_addr == match_addr);
    force_hit_d = hit && force_sel;
    tag_hit_d   = hit && !force_sel;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      force_hit <= 1'b0;
      tag_hit   <= 1'b0;
    end else begin
      force_hit <= force_hit_d;
      tag_hit   <= tag_hit_d;
    end
  end
endmodule // bds_bkpt_cmp

// >>> rtl/bds_pkg.sv
package bds_pkg;
  typedef enum logic [2:0] {
    BDS_RUN   = 3'b001,
    BDS_LOWP  = 3'b010,
    BDS_BGND  = 3'b100
  } bds_cpu_t;
endpackage

// >>> rtl/bds_regs.svh
`ifndef BDS_REGS_SVH
`define BDS_REGS_SVH

// status/control bit positions
`define BDS_SC_ENBDM_BIT    7
`define BDS_SC_ACTIVE_BIT   6
`define BDS_SC_BREAKPOINT_ENABLE_BIT   5
`define BDS_SC_FTS_BIT      4
`define BDS_SC_CLKSW_BIT    3
`define BDS_SC_WS_BIT       2
`define BDS_SC_WSF_BIT      1
`define BDS_SC_DVF_BIT      0

// reset values
`define BDS_SC_CTRL_RESET   4'h0
`define BDS_BKPT_RESET      16'h0000
`define BDS_FRST_RESET      8'h00
`define BDS_FRST_BIT        0

// target reset counter load in clocks; the pulse lasts one clock longer
`define BDS_FRST_PULSE      8'h10

`endif

// >>> rtl/bds_status_bkpt.sv
`timescale 1ns/10ps
`include "bds_regs.svh"
// Contract
// - in wait/stop only the force-to-background command is carried out
// - force-to-background in wait/stop brings the cpu to background
// - bit 2 is 1 in wait/stop or background entered from wait/stop
// - bit 1 set when memory command fails on wait/stop conflict
// - bit 0 data valid failure unused and reads 0
// - 16-bit breakpoint match register holds compared address
// - breakpoint register reached only by breakpoint read/write commands
// - breakpoint enable and force/tag select gate the comparator
// - force-reset bit 0 writable by debug command only, user ignored
// - force-reset register reads 0x00 and resets to zero
module bds_status_bkpt #(
  parameter int AW = 16
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          cpu_wait_stop,
  input  wire logic          cpu_active_bgnd,
  input  wire logic          cpu_wait_stop_entry,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic          cpu_addr_valid,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_background,
  input  wire logic          cmd_mem_access,
  input  wire logic          cmd_status_read,
  input  wire logic          cmd_control_write,
  input  wire logic          breakpoint_read_cmd,
  input  wire logic          breakpoint_write_cmd,
  input  wire logic          cmd_force_reset_write,
  input  wire logic          user_force_reset_write,
  input  wire logic          user_force_reset_read,
  input  wire logic [AW-1:0] cmd_wdata,
  output logic [AW-1:0]      cmd_rdata,
  output logic               cmd_rdata_valid,
  output logic               cmd_accepted,
  output logic               cmd_rejected,
  output logic               background_req,
  output logic               force_bkpt_req,
  output logic               tag_bkpt_req,
  output logic               target_reset_req,
  output logic [7:0]         user_rdata
);

  // ============================================================
  // state
  bds_pkg::bds_cpu_t cpu_st;
  logic            from_ws_q, from_ws_d;
  logic            wsf_q, wsf_d;
  logic [3:0]      ctrl_q, ctrl_d;
  logic [AW-1:0]   bkpt_q, bkpt_d;
  logic [7:0]      frst_cnt_q, frst_cnt_d;
  logic [AW-1:0]   rdata_d;
  logic            rvalid_d, acc_d, rej_d, bg_d, rst_d;
  logic            allowed, mem_fail, take;
  logic [7:0]      status_byte;

  always_comb begin
    if (cpu_wait_stop)
      cpu_st = bds_pkg::BDS_LOWP;
    else if (cpu_active_bgnd)
      cpu_st = bds_pkg::BDS_BGND;
    else
      cpu_st = bds_pkg::BDS_RUN;
  end

  // ============================================================
  // status byte assembly
  always_comb begin
    status_byte = 8'h00;
    status_byte[`BDS_SC_ENBDM_BIT]  = ctrl_q[3];
    status_byte[`BDS_SC_ACTIVE_BIT] = cpu_active_bgnd;
    status_byte[`BDS_SC_BREAKPOINT_ENABLE_BIT] = ctrl_q[2];
    status_byte[`BDS_SC_FTS_BIT]    = ctrl_q[1];
    status_byte[`BDS_SC_CLKSW_BIT]  = ctrl_q[0];
    status_byte[`BDS_SC_WS_BIT]     = cpu_wait_stop || from_ws_q;
    status_byte[`BDS_SC_WSF_BIT]    = wsf_q;
    status_byte[`BDS_SC_DVF_BIT]    = 1'b0;
  end

  // ============================================================
  // command decode
  function automatic logic in_low_power(bds_pkg::bds_cpu_t st);
    return st == bds_pkg::BDS_LOWP;
  endfunction

  always_comb begin
    allowed  = !in_low_power(cpu_st) || cmd_background;
    mem_fail = cmd_valid && cmd_mem_access && cpu_wait_stop_entry;
    take     = cmd_valid && allowed && !mem_fail;
  end

  // ============================================================
  // wait/stop status
  always_comb begin
    from_ws_d = from_ws_q;
    wsf_d     = wsf_q;
    // returning to run clears the wait/stop origin
    if (cpu_st == bds_pkg::BDS_RUN)
      from_ws_d = 1'b0;
    if (take && cmd_background && in_low_power(cpu_st))
      from_ws_d = 1'b1;
    // an accepted memory command clears the failure, a racing one sets it
    if (take && cmd_mem_access)
      wsf_d = 1'b0;
    if (mem_fail)
      wsf_d = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      from_ws_q <= 1'b0;
      wsf_q     <= 1'b0;
    end else begin
      from_ws_q <= from_ws_d;
      wsf_q     <= wsf_d;
    end
  end

  // ============================================================
  // control bits and breakpoint match address
  always_comb begin
    ctrl_d = ctrl_q;
    bkpt_d = bkpt_q;
    if (take && cmd_control_write)
      ctrl_d = {cmd_wdata[`BDS_SC_ENBDM_BIT], cmd_wdata[`BDS_SC_BREAKPOINT_ENABLE_BIT],
                cmd_wdata[`BDS_SC_FTS_BIT], cmd_wdata[`BDS_SC_CLKSW_BIT]};
    if (take && breakpoint_write_cmd)
      bkpt_d = cmd_wdata;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= `BDS_SC_CTRL_RESET;
      bkpt_q <= `BDS_BKPT_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      bkpt_q <= bkpt_d;
    end
  end

  // ============================================================
  // force reset
  always_comb begin
    frst_cnt_d = frst_cnt_q;
    rst_d      = (frst_cnt_q != 8'h00);
    if (frst_cnt_q != 8'h00)
      frst_cnt_d = frst_cnt_q - 8'h01;
    // only the debug command path reaches the force-reset bit
    if (take && cmd_force_reset_write && cmd_wdata[`BDS_FRST_BIT]) begin
      frst_cnt_d = `BDS_FRST_PULSE;
      rst_d      = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      frst_cnt_q       <= `BDS_FRST_RESET;
      target_reset_req <= 1'b0;
      user_rdata       <= 8'h00;
    end else begin
      frst_cnt_q       <= frst_cnt_d;
      target_reset_req <= rst_d;
      // user side sees zero and its writes have no path in
      user_rdata       <= `BDS_FRST_RESET;
    end
  end

  // ============================================================
  // command response
  always_comb begin
    rdata_d  = '0;
    rvalid_d = 1'b0;
    acc_d    = take;
    rej_d    = cmd_valid && !take;
    bg_d     = take && cmd_background;
    if (take && cmd_status_read) begin
      rdata_d  = AW'(status_byte);
      rvalid_d = 1'b1;
    end
    if (take && breakpoint_read_cmd) begin
      rdata_d  = bkpt_q;
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_rdata       <= '0;
      cmd_rdata_valid <= 1'b0;
      cmd_accepted    <= 1'b0;
      cmd_rejected    <= 1'b0;
      background_req  <= 1'b0;
    end else begin
      cmd_rdata       <= rdata_d;
      cmd_rdata_valid <= rvalid_d;
      cmd_accepted    <= acc_d;
      cmd_rejected    <= rej_d;
      background_req  <= bg_d;
    end
  end

  // ============================================================
  // breakpoint comparator
  bds_bkpt_cmp #(.AW(AW)) u_cmp (
    .mclk           (mclk),
    .reset          (reset),
    .enable         (ctrl_q[2]),
    .force_sel      (ctrl_q[1]),
    .match_addr     (bkpt_q),
    .cpu_addr       (cpu_addr),
    .cpu_addr_valid (cpu_addr_valid),
    .force_hit      (force_bkpt_req),
    .tag_hit        (tag_bkpt_req)
  );

endmodule // bds_status_bkpt

// >>> sim/bds_host_model.sv
`timescale 1ns/10ps
// ==============================
// debug host issuing decoded commands
module bds_host_model (
  input  wire logic        mclk,
  output logic             cmd_valid,
  output logic [6:0]       cmd_kind,
  output logic [15:0]      cmd_wdata
);
  initial begin
    cmd_valid = 1'h0;
    cmd_kind  = 7'h00;
    cmd_wdata = 16'h0000;
  end
  // drives one-hot command kind k with its data for one clock
  task automatic send(input int k, input logic [15:0] d);
    cmd_valid = 1'h1;
    cmd_kind  = 7'(1 << k);
    cmd_wdata = d;
    @(posedge mclk);
    #1;
  endtask
  // released data lines toggle so no stale value is seen
  task automatic idle();
    cmd_valid = 1'h0;
    cmd_kind  = 7'h00;
    cmd_wdata = ~cmd_wdata;
    @(posedge mclk);
    #1;
  endtask
endmodule // bds_host_model

// >>> sim/bds_status_bkpt_monitor.sv
`timescale 1ns/10ps
// ==============================
// port checker
module bds_chk #(
  parameter int AW = 16
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          cpu_wait_stop,
  input  wire logic          cpu_wait_stop_entry,
  input  wire logic          cpu_addr_valid,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_background,
  input  wire logic          cmd_mem_access,
  input  wire logic          cmd_status_read,
  input  wire logic          breakpoint_write_cmd,
  input  wire logic          breakpoint_read_cmd,
  input  wire logic          cmd_force_reset_write,
  input  wire logic          cmd_rejected,
  input  wire logic          background_req,
  input  wire logic [AW-1:0] cmd_wdata,
  input  wire logic [AW-1:0] cmd_rdata,
  input  wire logic          force_bkpt_req,
  input  wire logic          tag_bkpt_req,
  input  wire logic          target_reset_req,
  input  wire logic [7:0]    user_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic wc = cmd_valid && cpu_wait_stop;
  wire logic rc = cmd_valid && !cpu_wait_stop;
  AST_REJ: assert property (wc && !cmd_background |=> cmd_rejected)
    else $error("not refused");
  AST_BGND: assert property (wc && cmd_background |=> background_req)
    else $error("no background");
  AST_WSF: assert property (
    rc && cmd_mem_access && cpu_wait_stop_entry |=> cmd_rejected)
    else $error("mem not refused");
  AST_DVF: assert property (rc && cmd_status_read |=> !cmd_rdata[0])
    else $error("bit0 set");
  AST_BKPT: assert property (
    rc && breakpoint_write_cmd ##1 rc && breakpoint_read_cmd
    |=> cmd_rdata == $past(cmd_wdata, 2))
    else $error("bkpt readback");
  AST_HIT: assert property ((force_bkpt_req || tag_bkpt_req) |->
    $past(cpu_addr_valid) && !(force_bkpt_req && tag_bkpt_req))
    else $error("bad hit");
  AST_USR: assert property (user_rdata == 8'h00)
    else $error("user read");
  AST_FRST: assert property (
    rc && cmd_force_reset_write && cmd_wdata[0] |=> target_reset_req)
    else $error("no reset");
  cover property (background_req);
  cover property (force_bkpt_req);
  cover property (target_reset_req);
endmodule // bds_chk
bind bds_status_bkpt bds_chk #(.AW(AW)) i_chk (.mclk(mclk), .reset(reset),
  .cpu_wait_stop(cpu_wait_stop), .cpu_wait_stop_entry(cpu_wait_stop_entry),
  .cpu_addr_valid(cpu_addr_valid), .cmd_valid(cmd_valid),
  .cmd_background(cmd_background), .cmd_mem_access(cmd_mem_access),
  .cmd_status_read(cmd_status_read), .cmd_rejected(cmd_rejected),
  .breakpoint_write_cmd(breakpoint_write_cmd), .cmd_rdata(cmd_rdata),
  .breakpoint_read_cmd(breakpoint_read_cmd), .cmd_wdata(cmd_wdata),
  .cmd_force_reset_write(cmd_force_reset_write), .user_rdata(user_rdata),
  .background_req(background_req), .force_bkpt_req(force_bkpt_req),
  .tag_bkpt_req(tag_bkpt_req), .target_reset_req(target_reset_req));

// >>> sim/bds_status_bkpt_test.sv
`timescale 1ns/10ps
// ==============================
// test sequence
module bds_status_bkpt_test;
  logic        mclk, reset, ws, act, wse, av, uw, ur, cv;
  logic        rv, acc, rej, bg, fh, th, tr;
  logic [6:0]  ck;
  logic [7:0]  ud;
  logic [15:0] addr, w, wd, rd;
  logic [7:0]  cs [3] = '{8'hb8, 8'ha0, 8'h90};
  int          err_total, checked, n;
  bds_host_model i_h (.mclk(mclk), .cmd_valid(cv), .cmd_kind(ck),
    .cmd_wdata(wd));
  bds_status_bkpt #(.AW(16)) i_dut (.mclk(mclk), .reset(reset),
    .cpu_wait_stop(ws), .cpu_active_bgnd(act), .cpu_wait_stop_entry(wse),
    .cpu_addr(addr), .cpu_addr_valid(av), .cmd_valid(cv),
    .cmd_background(ck[0]), .cmd_mem_access(ck[1]), .cmd_status_read(ck[2]),
    .cmd_control_write(ck[3]), .breakpoint_read_cmd(ck[4]),
    .breakpoint_write_cmd(ck[5]), .cmd_force_reset_write(ck[6]),
    .user_force_reset_write(uw), .user_force_reset_read(ur), .cmd_wdata(wd),
    .cmd_rdata(rd), .cmd_rdata_valid(rv), .cmd_accepted(acc),
    .cmd_rejected(rej), .background_req(bg), .force_bkpt_req(fh),
    .tag_bkpt_req(th), .target_reset_req(tr), .user_rdata(ud));
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [15:0] stat(logic a, s, f, logic [7:0] c);
    return {8'h00, c[7], a, c[5:3], s, f, 1'h0};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {ws, act, wse, av, uw, ur, addr} = '0;
    reset = 1'h1;
    void'($urandom(27958));
    repeat (8) @(posedge mclk);
    #1 reset = 1'h0;
    {uw, ur} = 2'h3;
    i_h.idle();
    uw = 1'h0;
    i_h.idle();
    chk("user_wr", 16'h0000, {15'h0, tr});
    chk("user_rd", 16'h0000, {8'h00, ud});
    act = 1'h1;
    foreach (cs[i]) begin
      w = 16'($urandom);
      i_h.send(3, {8'h00, cs[i]});
      i_h.send(5, w);
      i_h.send(4, 16'h0000);
      chk("bkpt", w, rd);
      chk("bkpt_vld", 16'h0001, {15'h0, rv});
      i_h.send(2, 16'h0000);
      chk("stat", stat(1'h1, 1'h0, 1'h0, cs[i]), {8'h00, rd[7:0]});
      addr = w;
      av = 1'h1;
      i_h.idle();
      chk("hit", {14'h0, cs[i][5] & cs[i][4], cs[i][5] & ~cs[i][4]},
        {14'h0, fh, th});
      av = 1'h0;
    end
    {act, ws} = 2'h1;
    i_h.send(2, 16'h0000);
    chk("refuse", 16'h0001, {15'h0, rej});
    chk("refuse_vld", 16'h0000, {15'h0, rv});
    i_h.send(0, 16'h0000);
    chk("bgnd", 16'h0001, {15'h0, bg});
    {act, ws} = 2'h2;
    i_h.send(2, 16'h0000);
    chk("stat", stat(1'h1, 1'h1, 1'h0, 8'h90), {8'h00, rd[7:0]});
    {act, wse} = 2'h1;
    i_h.send(1, 16'h0000);
    chk("memfail", 16'h0001, {15'h0, rej});
    wse = 1'h0;
    i_h.send(2, 16'h0000);
    chk("stat", stat(1'h0, 1'h0, 1'h1, 8'h90), {8'h00, rd[7:0]});
    i_h.send(0, 16'h0000);
    act = 1'h1;
    i_h.send(1, 16'h0000);
    chk("retry", 16'h0001, {15'h0, acc});
    i_h.send(6, 16'h0001);
    for (n = 0; tr === 1'h1 && n < 40; n++) i_h.idle();
    chk("rst_len", 16'h0011, 16'(n));
    wrap_up();
  end
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule // bds_status_bkpt_test
